/* File: hw/spr_pll_ratio_decode.sv */
// System clock ratio decoder: latches the reset configuration and derives ratio and vco.
// Assumes synchronous inputs, a plain register port and a stable configuration word at reset.
// Overview of operation
// - Vco divider code 00 is /4, 01 is /8, 10 is /2, 11 reserved.
// - Both doubling bits clear: vco equals bus clock times divider.
// - Either doubling bit set: vco equals twice bus clock times divider.
// - Bus clock is input clock times one plus strap, times multiplier.
// - Strap low: bus-to-input ratio equals the multiplier's binary value.
//
// Local design decisions: the register addresses and the strobed register port.
`include "spr_consts.svh"

module spr_pll_ratio_decode (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] reset_config_word_low_i,
    input  wire logic        input_divide_strap_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    output logic      [4:0]  csb_ratio_o,
    output logic      [3:0]  vco_div_o,
    output logic      [28:0] vco_khz_o,
    output logic             cfg_invalid_o,
    output logic             cfg_valid_o
);

    spr_pkg::spr_state_t state_r;
    spr_pkg::spr_state_t state_nxt;
    spr_pkg::spr_cfg_t   cfg_r;
    spr_pkg::spr_cfg_t   cfg_nxt;
    spr_pkg::spr_res_t   res_r;
    spr_pkg::spr_res_t   res_nxt;
    logic [19:0]         in_khz_r;
    logic [19:0]         in_khz_nxt;
    logic                valid_r;
    logic                valid_nxt;
    logic [31:0]         rd_data_r;
    logic [31:0]         rd_data_nxt;

    logic [3:0]          div_c;
    logic                rsvd_c;
    logic [4:0]          ratio_c;
    logic [4:0]          vmul_c;
    logic [24:0]         csb_c;
    logic [29:0]         vco_c;
    logic                restart_c;
    logic                recap_c;

    // Divider decode
    always_comb begin
        rsvd_c = 1'b0;
        case (cfg_r.vco_sel)
            `SPR_VCO_CODE_4: div_c = `SPR_VCO_DIV_4;
            `SPR_VCO_CODE_8: div_c = `SPR_VCO_DIV_8;
            `SPR_VCO_CODE_2: div_c = `SPR_VCO_DIV_2;
            default: begin
                div_c  = 4'h0;
                rsvd_c = 1'b1;
            end
        endcase
    end

    // Ratio and frequency arithmetic
    always_comb begin
        ratio_c = cfg_r.strap ? {cfg_r.mult, 1'b0} : {1'b0, cfg_r.mult};
        csb_c   = in_khz_r * ratio_c;
        vmul_c  = (cfg_r.lb_dbl | cfg_r.mem_dbl) ? {div_c, 1'b0} : {1'b0, div_c};
        vco_c   = csb_c * vmul_c;
    end

    // Bus command decode; a new input frequency during calc or done restarts calc
    always_comb begin
        restart_c = 1'b0;
        recap_c   = 1'b0;
        if (wr_i && addr_i == `SPR_REG_IN_KHZ) begin
            restart_c = (state_r == spr_pkg::SPR_CALC) |
                        (state_r == spr_pkg::SPR_DONE);
        end
        if (wr_i && addr_i == `SPR_REG_CTRL) begin
            recap_c = wr_data_i[0] & (state_r == spr_pkg::SPR_DONE);
        end
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        valid_nxt = valid_r;
        case (state_r)
            spr_pkg::SPR_IDLE: begin
                state_nxt = spr_pkg::SPR_CAPTURE;
            end
            spr_pkg::SPR_CAPTURE: begin
                valid_nxt = 1'b0;
                state_nxt = spr_pkg::SPR_CALC;
            end
            spr_pkg::SPR_CALC: begin
                valid_nxt = 1'b1;
                state_nxt = spr_pkg::SPR_DONE;
            end
            spr_pkg::SPR_DONE: begin
                state_nxt = spr_pkg::SPR_DONE;
            end
            default: begin
                state_nxt = spr_pkg::SPR_IDLE;
            end
        endcase
        if (restart_c) begin
            state_nxt = spr_pkg::SPR_CALC;
            valid_nxt = 1'b0;
        end
        if (recap_c) begin
            state_nxt = spr_pkg::SPR_CAPTURE;
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= spr_pkg::SPR_IDLE;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Configuration capture
    always_comb begin
        cfg_nxt = cfg_r;
        if (state_r == spr_pkg::SPR_CAPTURE) begin
            cfg_nxt.lb_dbl  = reset_config_word_low_i[`SPR_LB_DBL_BIT];
            cfg_nxt.mem_dbl = reset_config_word_low_i[`SPR_MEM_DBL_BIT];
            cfg_nxt.vco_sel = reset_config_word_low_i[`SPR_VCO_SEL_HI:`SPR_VCO_SEL_LO];
            cfg_nxt.mult    = reset_config_word_low_i[`SPR_MULT_HI:`SPR_MULT_LO];
            cfg_nxt.strap   = input_divide_strap_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // Results
    always_comb begin
        res_nxt = res_r;
        if (state_r == spr_pkg::SPR_CALC) begin
            res_nxt.ratio   = ratio_c;
            res_nxt.vco_div = div_c;
            res_nxt.vco_khz = vco_c[28:0];
            res_nxt.invalid = rsvd_c | vco_c[29] |
                              (vco_c[28:0] < `SPR_VCO_MIN_KHZ) |
                              (vco_c[28:0] > `SPR_VCO_MAX_KHZ);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // Input clock frequency register
    always_comb begin
        in_khz_nxt = in_khz_r;
        if (wr_i && addr_i == `SPR_REG_IN_KHZ) begin
            in_khz_nxt = wr_data_i[19:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_khz_r <= `SPR_IN_KHZ_RST;
        end else begin
            in_khz_r <= in_khz_nxt;
        end
    end

    // Read port
    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `SPR_REG_IN_KHZ: rd_data_nxt = {12'h000, in_khz_r};
                `SPR_REG_CFG:    rd_data_nxt = {23'h00_0000, cfg_r};
                `SPR_REG_RATIO:  rd_data_nxt = {23'h00_0000, res_r.vco_div, res_r.ratio};
                `SPR_REG_VCO:    rd_data_nxt = {3'h0, res_r.vco_khz};
                `SPR_REG_STATUS: rd_data_nxt = {30'h0000_0000, res_r.invalid, valid_r};
                default:         rd_data_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_r <= 32'h0000_0000;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_o     = rd_data_r;
    assign csb_ratio_o   = res_r.ratio;
    assign vco_div_o     = res_r.vco_div;
    assign vco_khz_o     = res_r.vco_khz;
    assign cfg_invalid_o = res_r.invalid;
    assign cfg_valid_o   = valid_r;

    // Checks
    logic [29:0] chk_vco_w;
    assign chk_vco_w = in_khz_r * res_r.ratio * res_r.vco_div;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_capture;
        state_r == spr_pkg::SPR_CAPTURE;
    endsequence
    sequence s_calc_quiet;
        state_r == spr_pkg::SPR_CALC && !restart_c;
    endsequence
    sequence s_done_valid;
        state_r == spr_pkg::SPR_DONE && valid_r;
    endsequence

    a_capture_to_calc: assert property (s_capture |=> state_r == spr_pkg::SPR_CALC)
        else $error("capture did not move to calc");
    a_capture_to_done: assert property (s_capture ##1 s_calc_quiet |=> s_done_valid)
        else $error("capture did not reach done in two cycles");
    a_divider_decode: assert property (valid_r && !res_r.invalid |->
        res_r.vco_div == (cfg_r.vco_sel == 2'h0 ? 4'h4 :
                          cfg_r.vco_sel == 2'h1 ? 4'h8 : 4'h2))
        else $error("vco divider decode wrong");
    a_reserved_flag: assert property (valid_r && cfg_r.vco_sel == 2'h3 |->
        cfg_invalid_o)
        else $error("reserved divider not flagged");
    a_range_flag: assert property (valid_r && res_r.vco_div != 4'h0 |->
        cfg_invalid_o == (vco_khz_o < `SPR_VCO_MIN_KHZ || vco_khz_o > `SPR_VCO_MAX_KHZ))
        else $error("range flag wrong");
    a_vco_single: assert property (valid_r && !cfg_r.lb_dbl && !cfg_r.mem_dbl |->
        {1'b0, vco_khz_o} == chk_vco_w)
        else $error("single vco wrong");
    a_vco_double: assert property (valid_r && (cfg_r.lb_dbl || cfg_r.mem_dbl) |->
        {1'b0, vco_khz_o} == {chk_vco_w[28:0], 1'b0})
        else $error("doubled vco wrong");
    a_ratio_strap: assert property (valid_r |->
        csb_ratio_o == (cfg_r.strap ? {cfg_r.mult, 1'b0} : {1'b0, cfg_r.mult}))
        else $error("bus ratio wrong");
    a_ratio_plain: assert property ($rose(valid_r) && !cfg_r.strap |->
        csb_ratio_o[3:0] == cfg_r.mult && !csb_ratio_o[4])
        else $error("plain ratio wrong");
    a_ratio_zero: assert property (valid_r && csb_ratio_o == 5'h00 |->
        cfg_invalid_o)
        else $error("zero ratio not flagged");

    // Sequencer and register port checks
    a_restart_calc: assert property (restart_c |=>
        state_r == spr_pkg::SPR_CALC && !valid_r)
        else $error("frequency write did not restart calc");
    a_recapture_cmd: assert property (recap_c |=>
        state_r == spr_pkg::SPR_CAPTURE && !valid_r)
        else $error("recapture command not taken");
    a_valid_in_done: assert property (
        valid_r == (state_r == spr_pkg::SPR_DONE))
        else $error("valid flag out of step with sequencer");
    a_cfg_hold: assert property (state_r != spr_pkg::SPR_CAPTURE |=>
        $stable(cfg_r))
        else $error("configuration changed outside capture");
    a_res_hold: assert property (state_r != spr_pkg::SPR_CALC |=>
        $stable(res_r))
        else $error("results changed outside calc");
    a_in_khz_write: assert property (wr_i && addr_i == `SPR_REG_IN_KHZ |=>
        {12'h000, in_khz_r} == ($past(wr_data_i) & 32'h000F_FFFF))
        else $error("input frequency write lost");
    a_rdata_idle: assert property (!rd_i |=>
        rd_data_o == 32'h0000_0000)
        else $error("read data not cleared");
    a_vco_read: assert property (rd_i && addr_i == `SPR_REG_VCO |=>
        rd_data_o == {3'h0, $past(vco_khz_o)})
        else $error("vco read wrong");
    a_status_read: assert property (rd_i && addr_i == `SPR_REG_STATUS |=>
        rd_data_o == {30'h0000_0000, $past(cfg_invalid_o), $past(cfg_valid_o)})
        else $error("status read wrong");
    a_cfg_read: assert property (rd_i && addr_i == `SPR_REG_CFG |=>
        rd_data_o == {23'h00_0000, $past(cfg_r)})
        else $error("configuration read wrong");
    a_ratio_read: assert property (rd_i && addr_i == `SPR_REG_RATIO |=>
        rd_data_o == {23'h00_0000, $past(vco_div_o), $past(csb_ratio_o)})
        else $error("ratio read wrong");

endmodule // spr_pll_ratio_decode

/* File: hw/spr_consts.svh */
// Constants for the system clock ratio decoder: offsets, fields, resets.
// Assumes inclusion by bare name; definitions only.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// Register offsets, byte addresses
`define SPR_REG_IN_KHZ    8'h00
`define SPR_REG_CTRL      8'h04
`define SPR_REG_CFG       8'h08
`define SPR_REG_RATIO     8'h0C
`define SPR_REG_VCO       8'h10
`define SPR_REG_STATUS    8'h14

// Field positions in the low reset configuration word
`define SPR_LB_DBL_BIT    31
`define SPR_MEM_DBL_BIT   30
`define SPR_VCO_SEL_HI    29
`define SPR_VCO_SEL_LO    28
`define SPR_MULT_HI       27
`define SPR_MULT_LO       24

// Vco divider codes and values
`define SPR_VCO_CODE_4    2'h0
`define SPR_VCO_CODE_8    2'h1
`define SPR_VCO_CODE_2    2'h2
`define SPR_VCO_DIV_4     4'h4
`define SPR_VCO_DIV_8     4'h8
`define SPR_VCO_DIV_2     4'h2

// Permitted vco range in kHz
`define SPR_VCO_MIN_KHZ   29'h0009_27C0
`define SPR_VCO_MAX_KHZ   29'h0015_5CC0

// Reset value of the input clock frequency, kHz
`define SPR_IN_KHZ_RST    20'h0_8235

`endif

/* File: hw/spr_pkg.sv */
// Types for the system clock ratio decoder.
// Assumes nothing beyond compile order: before the decoder.
package spr_pkg;

    typedef enum logic [1:0] {
        SPR_IDLE    = 2'b00,
        SPR_CAPTURE = 2'b01,
        SPR_CALC    = 2'b11,
        SPR_DONE    = 2'b10
    } spr_state_t;

    typedef struct packed {
        logic       lb_dbl;
        logic       mem_dbl;
        logic [3:0] mult;
        logic [1:0] vco_sel;
        logic       strap;
    } spr_cfg_t;

    typedef struct packed {
        logic [4:0]  ratio;
        logic [3:0]  vco_div;
        logic [28:0] vco_khz;
        logic        invalid;
    } spr_res_t;

endpackage : spr_pkg

/* File: tb/spr_cfg_src.sv */
// Board model: presents the reset config word and the input divide strap.
// Assumes the bench sets cfg_i by non-blocking assignment after a clock edge.
module spr_cfg_src (
    input  wire logic              ref_clk_i,
    input  wire spr_pkg::spr_cfg_t cfg_i,
    output logic [31:0]            word_o,
    output logic                   strap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] fill_r = 24'h5A_C3E1;
    // Unused word bits keep moving
    always @(posedge ref_clk_i) begin
        fill_r <= {fill_r[22:0], fill_r[23] ^ fill_r[20]};
    end
    assign word_o  = {cfg_i.lb_dbl, cfg_i.mem_dbl, cfg_i.vco_sel, cfg_i.mult, fill_r};
    assign strap_o = cfg_i.strap;
endmodule // spr_cfg_src

/* File: tb/spr_pll_ratio_decode_test.sv */
// Self-checking bench for the system clock ratio decoder.
// Assumes the decoder, its package and constants header are compiled first.
`include "spr_consts.svh"
module spr_pll_ratio_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk_i, rst_n_i, wr_i, rd_i, strap, cfg_invalid_o, cfg_valid_o, e_inv;
    logic [7:0]        addr_i;
    logic [31:0]       wr_data_i, word, rd_data_o;
    logic [4:0]        csb_ratio_o, e_rat;
    logic [3:0]        vco_div_o, e_div;
    logic [28:0]       vco_khz_o;
    logic [19:0]       khz;
    logic [63:0]       e_vco;
    spr_pkg::spr_cfg_t cfg;
    int                err_count, n_compared;
    integer            seed;

    spr_cfg_src i_src (.ref_clk_i(ref_clk_i), .cfg_i(cfg), .word_o(word), .strap_o(strap));
    spr_pll_ratio_decode i_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_config_word_low_i(word),
        .input_divide_strap_i(strap), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
        .rd_i(rd_i), .rd_data_o(rd_data_o), .csb_ratio_o(csb_ratio_o), .vco_div_o(vco_div_o),
        .vco_khz_o(vco_khz_o), .cfg_invalid_o(cfg_invalid_o), .cfg_valid_o(cfg_valid_o));

    always #5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic wait_done();
        repeat (2) @(posedge ref_clk_i);
        #1;
        for (int n = 0; n < 8 && cfg_valid_o !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask

    function automatic logic [3:0] div_of(input logic [1:0] s);
        case (s)
            `SPR_VCO_CODE_4: return `SPR_VCO_DIV_4;
            `SPR_VCO_CODE_8: return `SPR_VCO_DIV_8;
            `SPR_VCO_CODE_2: return `SPR_VCO_DIV_2;
            default: return 4'h0;
        endcase
    endfunction

    // Divider code that keeps the vco in range, reserved code if none does
    function automatic logic [1:0] fit_sel(input spr_pkg::spr_cfg_t c, input logic [19:0] k);
        logic [63:0] v;
        fit_sel = 2'h3;
        for (int s = 0; s < 3; s++) begin
            v = 64'(k) * c.mult * div_of(2'(s)) * (c.strap ? 2 : 1) *
                ((c.lb_dbl | c.mem_dbl) ? 2 : 1);
            if (v >= 64'(`SPR_VCO_MIN_KHZ) && v <= 64'(`SPR_VCO_MAX_KHZ)) begin
                fit_sel = 2'(s);
            end
        end
    endfunction

    task automatic check_all();
        logic [31:0] d;
        e_rat = cfg.strap ? {cfg.mult, 1'b0} : {1'b0, cfg.mult};
        e_div = div_of(cfg.vco_sel);
        e_vco = 64'(khz) * e_rat * e_div * ((cfg.lb_dbl | cfg.mem_dbl) ? 2 : 1);
        e_inv = (e_div == 4'h0) || (e_vco < 600000) || (e_vco > 1400000);
        chk(32'(cfg_valid_o), 32'h0000_0001);
        chk(32'(csb_ratio_o), 32'(e_rat));
        chk(32'(vco_div_o), 32'(e_div));
        chk(32'(vco_khz_o), e_vco[31:0]);
        chk(32'(cfg_invalid_o), 32'(e_inv));
        rd(`SPR_REG_RATIO, d);
        chk(d, {23'h0, e_div, e_rat});
        rd(`SPR_REG_VCO, d);
        chk(d, e_vco[31:0]);
        rd(`SPR_REG_STATUS, d);
        chk(d, {30'h0, e_inv, 1'b1});
        rd(`SPR_REG_CFG, d);
        chk(d, 32'(cfg));
    endtask

    task automatic run(input spr_pkg::spr_cfg_t c, input logic [19:0] k);
        cfg <= c;
        khz = k;
        wr(`SPR_REG_IN_KHZ, 32'(k));
        wait_done();
        wr(`SPR_REG_CTRL, 32'h0000_0001);
        wait_done();
        check_all();
    endtask

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [19:0] lim [4];
        spr_pkg::spr_cfg_t c;
        logic [19:0] k;
        lim = '{20'h1_24F8, 20'h1_24F7, 20'h2_AB98, 20'h2_AB99};
        seed = 32'hA0E9_BC99;
        ref_clk_i = 1'b0;
        rst_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wr_data_i = 32'h0000_0000;
        cfg = 9'h040;
        khz = `SPR_IN_KHZ_RST;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_done();
        check_all();
        // Back to back reads, then the port falls back to zero
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= `SPR_REG_IN_KHZ;
        @(posedge ref_clk_i);
        addr_i <= `SPR_REG_STATUS;
        #1 chk(rd_data_o, {12'h000, khz});
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk(rd_data_o, {30'h0, e_inv, 1'b1});
        @(posedge ref_clk_i);
        #1 chk(rd_data_o, 32'h0000_0000);
        rd(`SPR_REG_IN_KHZ, d);
        chk(d, 32'(`SPR_IN_KHZ_RST));
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, d);
        chk(d, 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            run({2'b00, 4'h8, 2'(s), 1'b0}, `SPR_IN_KHZ_RST);
        end
        foreach (lim[i]) begin
            run(9'h010, lim[i]);
        end
        for (int i = 0; i < 40; i++) begin
            run(9'($random(seed)), 20'h0_8000 + 20'($random(seed) & 32'h0000_FFFF));
        end
        // Bench picks the divider that keeps the vco in range, reserved code if none does
        for (int i = 0; i < 16; i++) begin
            c = 9'($random(seed));
            k = 20'h0_8000 + 20'($random(seed) & 32'h0000_FFFF);
            c.vco_sel = fit_sel(c, k);
            run(c, k);
        end
        // Reset in mid-run: outputs clear, frequency register back to its reset value
        cfg <= {2'b01, 4'h5, 2'b10, 1'b1};
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1 chk({21'h0, csb_ratio_o, vco_div_o, cfg_invalid_o, cfg_valid_o}, 32'h0000_0000);
        chk({3'h0, vco_khz_o}, 32'h0000_0000);
        khz = `SPR_IN_KHZ_RST;
        wait_done();
        check_all();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        end_of_test();
    end
endmodule // spr_pll_ratio_decode_test
